/* hdl/spc_dev.sv */
`timescale 1ns/1ps
module spc_dev
    import spc_pkg::*;
(
    input  wire logic        clk_i,      // CPU clock
    input  wire logic        rst_i,      // Async reset
    input  wire logic [15:0] addr_i,     // Register address
    input  wire logic        wr_i,       // Write strobe
    input  wire logic        rd_i,       // Read strobe
    input  wire logic [7:0]  wdata_i,    // Write data
    output logic      [7:0]  rdata_o,    // Read data, cycle after rd_i
    input  wire logic        wait_i,     // CPU in wait
    input  wire logic        halt_i,     // CPU in halt
    input  wire logic        irq_mask_i, // CPU interrupt mask
    output logic             irq_o,      // Interrupt request
    output logic             wake_o,     // Wake from wait/halt
    spc_if.dev               lnk         // Serial link
);
    logic [3:0] pin_raw, s1_r, s2_r, s3_r, pin_r;
    logic       sck_f, mosi_f, miso_f, ss_f;
    logic [7:0] cr_r;
    logic [2:0] ctl_r;
    logic       done_r, wcol_r, ovr_r, mode_fault_flag_r, arm_r, arm_mode_fault_flag_r;
    logic [7:0] rxbuf_r;
    logic       busy_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic       bit_r;
    logic [6:0] div_r;
    logic       sck_r, sck_d_r, halt_d_r, halt_rcv_r;
    logic       sck_oe_r, mosi_oe_r, miso_oe_r;
    logic       master, en, pol, pha, ss_eff, run, fault;
    logic       wr_data, rd_data, wr_cr, csr_acc, rd_csr, xfer, wr_ok;
    logic       edge_ev, sample, rx_in, fin;
    logic [7:0] done_byte;
    logic [6:0] half;

    assign pin_raw = {lnk.sck, lnk.mosi, lnk.miso, lnk.ss_n};

    // Three-stage input filter per pin
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                s1_r[i]  <= SPC_PIN_RST[i];
                s2_r[i]  <= SPC_PIN_RST[i];
                s3_r[i]  <= SPC_PIN_RST[i];
                pin_r[i] <= SPC_PIN_RST[i];
            end else begin
                s1_r[i] <= pin_raw[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i]) begin
                    pin_r[i] <= s3_r[i];
                end
            end
        end
    end

    assign {sck_f, mosi_f, miso_f, ss_f} = pin_r;

    assign master  = cr_r[CR_MS];
    assign en      = cr_r[CR_PE];
    assign pol     = cr_r[CR_POL];
    assign pha     = cr_r[CR_PHA];
    assign ss_eff  = ctl_r[CSR_SSM] ? ctl_r[CSR_SSI] : ss_f;
    assign run     = ~halt_i | halt_rcv_r;
    assign fault   = run & en & master & ~ss_eff;
    assign wr_data = wr_i & ~halt_i & (addr_i == SPC_DATA_ADDR);
    assign rd_data = rd_i & ~halt_i & (addr_i == SPC_DATA_ADDR);
    assign wr_cr   = wr_i & ~halt_i & (addr_i == SPC_CTRL_ADDR);
    assign csr_acc = (wr_i | rd_i) & ~halt_i & (addr_i == SPC_CSR_ADDR);
    assign rd_csr  = rd_i & ~halt_i & (addr_i == SPC_CSR_ADDR);
    assign xfer    = busy_r | (cnt_r != '0);
    assign wr_ok   = wr_data & ~xfer & (~done_r | arm_r);
    assign half    = spc_half({cr_r[CR_DIV2], cr_r[CR_RT1], cr_r[CR_RT0]});
    assign edge_ev = master ? (busy_r & (div_r == '0))
                            : (en & ~ss_eff & (sck_f != sck_d_r));
    assign sample  = (cnt_r[0] == pha);
    assign rx_in   = master ? miso_f : mosi_f;
    assign done_byte = pha ? {sh_r[6:0], rx_in} : {sh_r[6:0], bit_r};
    assign fin     = run & en & ~fault & edge_ev & (cnt_r == SPC_EDGE_LAST) & (master | ~ss_eff);

    // Halt entry: only a selected slave stays live
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            halt_d_r   <= 1'b0;
            halt_rcv_r <= 1'b0;
        end else begin
            halt_d_r <= halt_i;
            if (halt_i & ~halt_d_r) begin
                halt_rcv_r <= en & ~master & ~ss_eff;
            end else if (~halt_i) begin
                halt_rcv_r <= 1'b0;
            end
        end
    end

    // Control registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cr_r  <= SPC_CR_RST;
            ctl_r <= SPC_CTL_RST;
        end else begin
            if (wr_cr) begin
                cr_r <= wdata_i;
                if (mode_fault_flag_r & ~arm_mode_fault_flag_r) begin
                    cr_r[CR_PE] <= 1'b0;
                    cr_r[CR_MS] <= 1'b0;
                end
            end
            if (fault) begin
                cr_r[CR_PE] <= 1'b0;
                cr_r[CR_MS] <= 1'b0;
            end
            if (csr_acc & wr_i) begin
                ctl_r <= wdata_i[2:0];
            end
        end
    end

    // Shift engine, shared by master and slave
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_r  <= 1'b0;
            cnt_r   <= '0;
            sh_r    <= '0;
            bit_r   <= 1'b0;
            div_r   <= '0;
            sck_r   <= 1'b0;
            sck_d_r <= SPC_PIN_RST[3]; // Matches filter reset, no false edge
        end else if (run) begin
            sck_d_r <= sck_f;
            if (~en | fault) begin
                busy_r <= 1'b0;
                cnt_r  <= '0;
            end else if (wr_ok) begin
                sh_r <= wdata_i;
                if (master) begin
                    busy_r <= 1'b1;
                    cnt_r  <= '0;
                    div_r  <= half - 7'h01;
                end
            end else if (~master & ss_eff) begin
                cnt_r <= '0;
            end else if (edge_ev) begin
                if (master) begin
                    sck_r <= ~sck_r;
                    div_r <= half - 7'h01;
                end
                if (sample) begin
                    bit_r <= rx_in;
                end else if (cnt_r != '0) begin
                    sh_r <= {sh_r[6:0], bit_r};
                end
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == SPC_EDGE_LAST) begin
                    busy_r <= 1'b0;
                    sh_r   <= done_byte;
                end
            end else if (busy_r) begin
                div_r <= div_r - 7'h01;
            end
            if (~busy_r | ~en | fault) begin
                sck_r <= pol;
            end
        end
    end

    // Status flags; hardware set wins over clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_r     <= 1'b0;
            wcol_r     <= 1'b0;
            ovr_r      <= 1'b0;
            mode_fault_flag_r     <= 1'b0;
            arm_r      <= 1'b0;
            arm_mode_fault_flag_r <= 1'b0;
            rxbuf_r    <= '0;
        end else begin
            if (fin) begin
                done_r <= 1'b1;
            end else if (arm_r & (rd_data | wr_data)) begin
                done_r <= 1'b0;
            end
            if (wr_data & xfer) begin
                wcol_r <= 1'b1;
            end else if (arm_r & (rd_data | wr_data)) begin
                wcol_r <= 1'b0;
            end
            arm_r      <= (csr_acc & (done_r | wcol_r)) | (arm_r & ~(rd_data | wr_data));
            ovr_r      <= (fin & done_r) | (ovr_r & ~rd_csr);
            if (fin & ~done_r) begin
                rxbuf_r <= done_byte;
            end
            mode_fault_flag_r     <= fault | (mode_fault_flag_r & ~(wr_cr & arm_mode_fault_flag_r));
            arm_mode_fault_flag_r <= (rd_csr & mode_fault_flag_r) | (arm_mode_fault_flag_r & ~wr_cr);
        end
    end

    // Read port, interrupt and wake outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= SPC_RD_NONE;
            irq_o   <= 1'b0;
            wake_o  <= 1'b0;
        end else begin
            if (rd_i & ~halt_i) begin
                case (addr_i)
                    SPC_DATA_ADDR: rdata_o <= rxbuf_r;
                    SPC_CTRL_ADDR: rdata_o <= cr_r;
                    SPC_CSR_ADDR:  rdata_o <= {done_r, wcol_r, ovr_r, mode_fault_flag_r, 1'b0, ctl_r};
                    default:       rdata_o <= SPC_RD_NONE;
                endcase
            end
            irq_o  <= cr_r[CR_IE] & (done_r | mode_fault_flag_r | ovr_r) & ~irq_mask_i;
            wake_o <= cr_r[CR_IE] & ((wait_i & (done_r | mode_fault_flag_r | ovr_r))
                                     | (halt_i & done_r & ~master));
        end
    end

    // Pin drivers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_oe_r  <= 1'b0;
            mosi_oe_r <= 1'b0;
            miso_oe_r <= 1'b0;
        end else if (run) begin
            sck_oe_r  <= en & master & ~fault;
            mosi_oe_r <= en & master & ~fault & ~ctl_r[CSR_SOD];
            miso_oe_r <= en & ~master & ~ss_eff & ~ctl_r[CSR_SOD];
        end
    end

    assign lnk.dev_sck_o   = sck_r;
    assign lnk.dev_sck_oe  = sck_oe_r;
    assign lnk.dev_mosi_o  = sh_r[7];
    assign lnk.dev_mosi_oe = mosi_oe_r;
    assign lnk.dev_miso_o  = sh_r[7];
    assign lnk.dev_miso_oe = miso_oe_r;
endmodule // spc_dev

/* hdl/spc_fifo.sv */
`timescale 1ns/1ps
module spc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk_i,       // CPU clock
    input  wire logic         rst_i,       // Async reset
    input  wire logic [W-1:0] in_data_i,   // Write data
    input  wire logic         in_valid_i,  // Write request
    output logic              in_ready_o,  // Not full
    output logic [W-1:0]      out_data_o,  // Head word
    output logic              out_valid_o, // Not empty
    input  wire logic         out_ready_i  // Pop
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam logic [AW:0] FULL = (AW+1)'(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign push       = in_valid_i & in_ready_o;
    assign pop        = out_valid_o & out_ready_i;
    assign out_data_o = mem[rp_r];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_r        <= '0;
            rp_r        <= '0;
            cnt_r       <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r       <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
            in_ready_o  <= (cnt_r + (AW+1)'(push) - (AW+1)'(pop)) != FULL;
            out_valid_o <= (cnt_r + (AW+1)'(push) - (AW+1)'(pop)) != '0;
        end
    end
endmodule // spc_fifo

/* hdl/spc_if.sv */
`timescale 1ns/1ps
interface spc_if;
    logic dev_sck_o;
    logic dev_sck_oe;
    logic dev_mosi_o;
    logic dev_mosi_oe;
    logic dev_miso_o;
    logic dev_miso_oe;
    logic ptn_sck_o;
    logic ptn_sck_oe;
    logic ptn_mosi_o;
    logic ptn_mosi_oe;
    logic ptn_ss_n_o;
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;

    // Wire levels; undriven lines float high
    assign sck  = dev_sck_oe ? dev_sck_o : (ptn_sck_oe ? ptn_sck_o : 1'b1);
    assign mosi = dev_mosi_oe ? dev_mosi_o : (ptn_mosi_oe ? ptn_mosi_o : 1'b1);
    assign miso = dev_miso_oe ? dev_miso_o : 1'b1;
    assign ss_n = ptn_ss_n_o;

    modport dev (
        input  sck, mosi, miso, ss_n,
        output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe
    );
    modport ptn (
        input  miso,
        output ptn_sck_o, ptn_sck_oe, ptn_mosi_o, ptn_mosi_oe, ptn_ss_n_o
    );
endinterface

/* hdl/spc_pkg.sv */
package spc_pkg;

    // Register addresses
    localparam logic [15:0] SPC_DATA_ADDR = 16'h0011;
    localparam logic [15:0] SPC_CTRL_ADDR = 16'h0012;
    localparam logic [15:0] SPC_CSR_ADDR  = 16'h0013;

    // serial_control fields
    localparam int CR_IE   = 7;
    localparam int CR_PE   = 6;
    localparam int CR_DIV2 = 5;
    localparam int CR_MS   = 4;
    localparam int CR_POL  = 3;
    localparam int CR_PHA  = 2;
    localparam int CR_RT1  = 1;
    localparam int CR_RT0  = 0;

    // serial_control_status fields
    localparam int CSR_DONE = 7;
    localparam int CSR_WCOL = 6;
    localparam int CSR_OVR  = 5;
    localparam int CSR_MODE_FAULT_FLAG = 4;
    localparam int CSR_SOD  = 2;
    localparam int CSR_SSM  = 1;
    localparam int CSR_SSI  = 0;

    localparam logic [7:0] SPC_CR_RST   = 8'h00;
    localparam logic [2:0] SPC_CTL_RST  = 3'h0;
    localparam logic [7:0] SPC_RD_NONE  = 8'h00;
    localparam logic [3:0] SPC_PIN_RST  = 4'hf;
    localparam logic [3:0] SPC_EDGE_LAST = 4'hf;

    typedef enum logic [3:0] {
        SPC_IDLE  = 4'b0001,
        SPC_SETUP = 4'b0010,
        SPC_SHIFT = 4'b0100,
        SPC_GAP   = 4'b1000
    } spc_state_t;

    // Half period of the serial clock in CPU cycles, by {div2, rate}
    function automatic logic [6:0] spc_half(input logic [2:0] code);
        case (code)
            3'h4:    spc_half = 7'h02;
            3'h0:    spc_half = 7'h04;
            3'h1:    spc_half = 7'h08;
            3'h6:    spc_half = 7'h10;
            3'h2:    spc_half = 7'h20;
            3'h3:    spc_half = 7'h40;
            default: spc_half = 7'h04;
        endcase
    endfunction

endpackage

/* hdl/spc_ptn.sv */
`timescale 1ns/1ps
module spc_ptn
    import spc_pkg::*;
#(
    parameter int HALF  = 16,
    parameter int DEPTH = 8
) (
    input  wire logic       clk_i,      // CPU clock
    input  wire logic       rst_i,      // Async reset
    input  wire logic       en_i,       // Drive the link as master
    input  wire logic       clock_polarity_bit_i,     // Clock idle level
    input  wire logic       clock_phase_bit_i,     // Clock phase
    input  wire logic       hold_sel_i, // Keep select low between bytes
    input  wire logic [7:0] tx_data_i,  // Byte to send
    input  wire logic       tx_valid_i, // Byte offered
    output logic            tx_ready_o, // Buffer has room
    output logic [7:0]      rx_data_o,  // Byte received
    output logic            rx_valid_o, // One-cycle pulse with rx_data_o
    spc_if.ptn              lnk         // Serial link
);
    localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

    spc_state_t st_r;
    logic [7:0] fd;
    logic       fv;
    logic       pop;
    logic [2:0] ms_r;
    logic       miso_r;
    logic [7:0] tim_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic       bit_r;
    logic       sck_r;
    logic       ss_n_r;
    logic       oe_r;
    logic       tick;
    logic       sample;

    spc_fifo #(.W(8), .D(DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (tx_data_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .out_data_o  (fd),
        .out_valid_o (fv),
        .out_ready_i (pop)
    );

    assign pop    = (st_r == SPC_IDLE) & en_i & fv;
    assign tick   = (tim_r == '0);
    assign sample = (cnt_r[0] == clock_phase_bit_i);

    // Input filter for the slave data line
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ms_r   <= '1;
            miso_r <= 1'b1;
        end else begin
            ms_r <= {ms_r[1:0], lnk.miso};
            if (ms_r[1] == ms_r[2]) begin
                miso_r <= ms_r[2];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r       <= SPC_IDLE;
            tim_r      <= '0;
            cnt_r      <= '0;
            sh_r       <= '0;
            bit_r      <= 1'b0;
            sck_r      <= 1'b0;
            ss_n_r     <= 1'b1;
            oe_r       <= 1'b0;
            rx_data_o  <= '0;
            rx_valid_o <= 1'b0;
        end else begin
            oe_r       <= en_i;
            rx_valid_o <= 1'b0;
            tim_r      <= tick ? '0 : tim_r - 8'h01;
            case (st_r)
                SPC_IDLE: begin
                    sck_r  <= clock_polarity_bit_i;
                    ss_n_r <= ~(en_i & hold_sel_i);
                    if (pop) begin
                        sh_r   <= fd;
                        ss_n_r <= 1'b0;
                        tim_r  <= HALF_M1;
                        st_r   <= SPC_SETUP;
                    end
                end
                SPC_SETUP: begin
                    cnt_r <= '0;
                    if (tick) begin
                        tim_r <= HALF_M1;
                        st_r  <= SPC_SHIFT;
                    end
                end
                SPC_SHIFT: begin
                    if (tick) begin
                        sck_r <= ~sck_r;
                        tim_r <= HALF_M1;
                        cnt_r <= cnt_r + 4'h1;
                        if (sample) begin
                            bit_r <= miso_r;
                        end else if (cnt_r != '0) begin
                            sh_r <= {sh_r[6:0], bit_r};
                        end
                        if (cnt_r == SPC_EDGE_LAST) begin
                            rx_data_o  <= clock_phase_bit_i ? {sh_r[6:0], miso_r} : {sh_r[6:0], bit_r};
                            rx_valid_o <= 1'b1;
                            st_r       <= SPC_GAP;
                        end
                    end
                end
                SPC_GAP: begin
                    ss_n_r <= ~hold_sel_i;
                    if (tick) begin
                        st_r <= SPC_IDLE;
                    end
                end
                default: st_r <= SPC_IDLE;
            endcase
        end
    end

    assign lnk.ptn_sck_o   = sck_r;
    assign lnk.ptn_sck_oe  = oe_r;
    assign lnk.ptn_mosi_o  = sh_r[7];
    assign lnk.ptn_mosi_oe = oe_r;
    assign lnk.ptn_ss_n_o  = ss_n_r;
endmodule // spc_ptn

/* test/spc_assertions.sv */
`timescale 1ns/1ps
module spc_assertions (
    input wire logic clk_i,       // Clock
    input wire logic rst_i,       // Reset
    input wire logic sck,         // Clock wire
    input wire logic ss_n,        // Select wire
    input wire logic dev_sck_oe,  // Device drives clock
    input wire logic dev_mosi_oe, // Device drives data
    input wire logic ptn_sck_oe,  // Partner drives clock
    input wire logic ptn_mosi_oe  // Partner drives data
);
    logic       sck_r;
    logic       idle_r;
    logic [4:0] cnt_r;
    logic [3:0] gap_r;
    logic       chg;
    assign chg = sck != sck_r;
    // Cycles since the last clock change
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_r <= 1'h1;
            gap_r <= 4'hf;
        end else begin
            sck_r <= sck;
            gap_r <= chg ? 4'h1 : (gap_r == 4'hf ? gap_r : gap_r + 4'h1);
        end
    end
    // Edges inside a frame, idle level at its start
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r  <= 5'h00;
            idle_r <= 1'h1;
        end else begin
            cnt_r  <= ss_n ? 5'h00 : cnt_r + {4'h0, chg};
            idle_r <= ss_n ? sck : idle_r;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence sel_start;
        $fell(ss_n);
    endsequence
    sequence sel_end;
        $rose(ss_n);
    endsequence
    sck_one_drv_a: assert property (!(dev_sck_oe && ptn_sck_oe))
        else $error("clock driven twice");
    mosi_one_drv_a: assert property (!(dev_mosi_oe && ptn_mosi_oe))
        else $error("data line driven twice");
    setup_quiet_a: assert property (sel_start |=> $stable(sck)[*8])
        else $error("clock moved during setup");
    edge_count_a: assert property (sel_end |-> cnt_r + {4'h0, chg} == 5'h10)
        else $error("frame edge count wrong");
    idle_level_a: assert property (sel_end |-> sck == idle_r)
        else $error("clock not back at idle");
    ptn_spacing_a: assert property (chg && !ss_n && !dev_sck_oe |-> gap_r >= 4'h8)
        else $error("partner edges too close");
    dev_spacing_a: assert property (chg && dev_sck_oe && $past(dev_sck_oe) |-> gap_r >= 4'h2)
        else $error("device edges too close");
    gap_hold_a: assert property (sel_end |=> ss_n[*8])
        else $error("select gap too short");
endmodule // spc_assertions

/* test/test_spc_control_low_power_irq.sv */
`timescale 1ns/1ps
module test_spi_control_low_power_irq;
    import spc_pkg::*;
    logic        clk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, rd_d = 1'h0, s;
    logic        wait_i = 1'h0, halt_i = 1'h0, irq_mask_i = 1'h0, en = 1'h1, clock_polarity_bit = 1'h0, clock_phase_bit = 1'h0;
    logic        tx_valid = 1'h0, irq_o, wake_o, tx_ready, rx_valid;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0]  wdata_i = 8'h00, tx_data = 8'h00, rdata_o, rx_data, rs = 8'h45, t, u;
    logic [7:0]  q_rd[$], q_rx[$];
    logic [2:0]  code[6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
    logic [7:0]  div[6] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    int          n_errors = 0, n_checks = 0, i, k, n;

    spc_if lnk();
    spc_dev i_spc_dev (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .wait_i(wait_i), .halt_i(halt_i), .irq_mask_i(irq_mask_i),
        .irq_o(irq_o), .wake_o(wake_o), .lnk(lnk));
    spc_ptn #(.HALF(16), .DEPTH(8)) i_spc_ptn (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .clock_polarity_bit_i(clock_polarity_bit),
        .clock_phase_bit_i(clock_phase_bit), .hold_sel_i(1'h0), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
        .rx_data_o(rx_data), .rx_valid_o(rx_valid), .lnk(lnk));
    spc_assertions i_spc_assertions (.clk_i(clk_i), .rst_i(rst_i), .sck(lnk.sck), .ss_n(lnk.ss_n),
        .dev_sck_oe(lnk.dev_sck_oe), .dev_mosi_oe(lnk.dev_mosi_oe), .ptn_sck_oe(lnk.ptn_sck_oe),
        .ptn_mosi_oe(lnk.ptn_mosi_oe));

    always #2.5 clk_i = ~clk_i;

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t reg got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_rx(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t link got %h exp %h", $time, g, e);
        end
    endtask

    task summarize;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'h1;
        @(posedge clk_i);
        wr_i <= 1'h0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        q_rd.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'h0;
    endtask

    task automatic send(input logic [7:0] b, input logic [7:0] e);
        @(posedge clk_i);
        tx_data <= b;
        tx_valid <= 1'h1;
        q_rx.push_back(e);
        @(posedge clk_i);
        tx_valid <= 1'h0;
    endtask

    // 0 irq, 1 wake, 2 all partner bytes seen
    task automatic hold_for(input int w);
        for (int j = 0; j < 5000; j++) begin
            @(posedge clk_i);
            if (w == 0 ? irq_o === 1'h1 : w == 1 ? wake_o === 1'h1 : q_rx.size() == 0)
                return;
        end
        chk_reg(8'h00, 8'h01);
    endtask

    always @(posedge clk_i) begin
        if (rd_d)
            chk_reg(rdata_o, q_rd.pop_front());
        if (rx_valid === 1'h1)
            chk_rx(rx_data, q_rx.pop_front());
        rd_d <= rd_i;
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        chk_reg(8'h00, 8'h01);
        summarize();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        rd(SPC_CTRL_ADDR, 8'h00);
        rd(SPC_CSR_ADDR, 8'h00);
        rd(16'h0014, 8'h00);
        for (k = 0; k < 4; k++) begin
            wr(SPC_CTRL_ADDR, 8'h00);
            clock_polarity_bit <= k[1];
            clock_phase_bit <= k[0];
            wr(SPC_CTRL_ADDR, 8'hc0 | 8'(k << 2));
            rs = lfsr(rs);
            t = rs;
            wr(SPC_DATA_ADDR, t);
            rs = lfsr(rs);
            send(rs, t);
            hold_for(0);
            rd(SPC_CSR_ADDR, 8'h80);
            rd(SPC_DATA_ADDR, rs);
            t = rs;
            rs = lfsr(rs);
            send(rs, t);
            hold_for(0);
            rd(SPC_CSR_ADDR, 8'h80);
            rd(SPC_DATA_ADDR, rs);
        end
        wait_i <= 1'h1;
        t = rs;
        rs = lfsr(rs);
        u = rs;
        send(u, t);
        hold_for(0);
        rs = lfsr(rs);
        send(rs, u);
        hold_for(2);
        repeat (8) @(posedge clk_i);
        hold_for(1);
        rd(SPC_CSR_ADDR, 8'ha0);
        rd(SPC_DATA_ADDR, u);
        rd(SPC_CSR_ADDR, 8'h00);
        wait_i <= 1'h0;
        wr(SPC_CSR_ADDR, 8'h02);
        halt_i <= 1'h1;
        t = rs;
        rs = lfsr(rs);
        send(rs, t);
        hold_for(1);
        irq_mask_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        chk_reg({7'h00, irq_o}, 8'h00);
        halt_i <= 1'h0;
        irq_mask_i <= 1'h0;
        rd(SPC_CSR_ADDR, 8'h82);
        rd(SPC_DATA_ADDR, rs);
        t = rs;
        rs = lfsr(rs);
        send(rs, t);
        hold_for(0);
        rd(SPC_CSR_ADDR, 8'h82);
        rd(SPC_DATA_ADDR, rs);
        en <= 1'h0;
        clock_polarity_bit <= 1'h0;
        clock_phase_bit <= 1'h0;
        wr(SPC_CSR_ADDR, 8'h03);
        for (k = 0; k < 6; k++) begin
            wr(SPC_CTRL_ADDR, 8'h00);
            wr(SPC_CTRL_ADDR, 8'hd0 | {2'h0, code[k][2], 3'h0, code[k][1:0]});
            wr(SPC_DATA_ADDR, rs);
            s = lnk.sck;
            for (i = 0; i < 300 && lnk.sck === s; i++) @(negedge clk_i);
            s = lnk.sck;
            n = 0;
            while (lnk.sck === s && n < 300) begin
                @(negedge clk_i);
                n++;
            end
            chk_reg(8'(n * 2), div[k]);
            wr(SPC_DATA_ADDR, 8'h00);
            hold_for(0);
            rd(SPC_CSR_ADDR, 8'hc3);
            rd(SPC_DATA_ADDR, 8'hff);
        end
        wr(SPC_CSR_ADDR, 8'h02);
        hold_for(0);
        rd(SPC_CSR_ADDR, 8'h12);
        rd(SPC_CTRL_ADDR, 8'h83);
        wr(SPC_CTRL_ADDR, 8'h00);
        clock_polarity_bit <= 1'h1;
        @(posedge clk_i);
        tx_valid <= 1'h1;
        n = 0;
        repeat (12) begin
            @(posedge clk_i);
            if (tx_ready === 1'h1) begin
                n++;
                q_rx.push_back(8'hff);
            end
        end
        tx_valid <= 1'h0;
        chk_reg(8'(n), 8'h08);
        en <= 1'h1;
        hold_for(2);
        summarize();
    end
endmodule // test_spi_control_low_power_irq
